// *** src/lrp_fabric.sv ***
// Purpose: logic block register controls, row/column routing, io elements
// Assumes: all inputs but i_rstn synchronous to i_sys_clk; config over APB
// Notes: routing is combinational; async register effects are visible
//        at once and captured at the next edge
`timescale 1ns/1ns
`default_nettype none
module lrp_fabric
  import lrp_pkg::*;
(
  input  wire logic                       i_sys_clk,           // 20 MHz
  input  wire logic                       i_rstn,              // async, low
  input  wire logic                       i_psel,              // apb select
  input  wire logic                       i_penable,           // apb enable
  input  wire logic                       i_pwrite,            // apb write
  input  wire logic [7:0]                 i_paddr,             // apb address
  input  wire logic [31:0]                i_pwdata,            // apb wdata
  output logic      [31:0]                o_prdata,            // apb rdata
  output logic                            o_pready,            // apb ready
  output logic                            o_pslverr,           // apb error
  input  wire logic [LRP_NLE-1:0]         i_le_d,              // lut results
  input  wire logic [LRP_NLE-1:0]         i_elem_data_in_d,    // load data
  input  wire logic                       i_block_ctrl_line_a, // load line
  input  wire logic                       i_block_ctrl_line_b, // clear line
  output logic      [LRP_NLE-1:0]         o_le_out,            // element out
  input  wire logic [LRP_NCOL-1:0]        i_row_ext,           // other rows
  input  wire logic [LRP_NCCH-1:0]        i_col_ext,           // other cols
  input  wire logic [LRP_NDED-1:0]        i_ded_in,            // dedicated
  output logic      [LRP_NCOL-1:0]        o_row_chan,          // row bus
  output logic      [LRP_NCCH-1:0]        o_col_chan,          // column bus
  output logic [LRP_NCOL+LRP_NDED-1:0]    o_block_local,       // local feed
  input  wire logic [LRP_NIO-1:0]         i_pad_in,            // pad levels
  output logic      [LRP_NIO-1:0]         o_pad_out,           // pad drive
  output logic      [LRP_NIO-1:0]         o_pad_oe             // pad enable
);
  // ***********************************************
  // assertion clocking, shared by every check below
  // ***********************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // ***********************************************
  // functions
  // ***********************************************
  // one row channel by index, zero when out of range
  function automatic logic pick_row(input logic [LRP_NCOL-1:0] bus,
                                    input logic [4:0] idx);
    return (idx < LRP_NCOL) ? bus[idx[3:0]] : 1'b0;
  endfunction

  // peripheral source: dedicated input or row channel
  function automatic logic pick_src(input logic [4:0] s,
                                    input logic [LRP_NDED-1:0] ded,
                                    input logic [LRP_NCOL-1:0] row);
    return (s < LRP_SRC_ROW) ? ded[s[1:0]]
         : pick_row(row, s - LRP_SRC_ROW);
  endfunction

  // ***********************************************
  // registers and decode
  // ***********************************************
  logic [1:0]                    async_reg;  // element async mode
  logic [LRP_NCCH-1:0]           coldrv_reg; // column drive enables
  logic [2*LRP_NLE-1:0]          rowsel_reg; // two bits per element
  logic [LRP_NPER*LRP_SRC_W-1:0] psrc_reg;   // five bits per line
  logic [1:0]                    pfunc_reg;  // 1 = shared line is enable
  logic [31:0]                   ioe_reg [LRP_NIO]; // io element configs
  logic [1:0]                    clk_prev_reg; // last clock line levels
  logic [LRP_NLE-1:0]            le_q;       // element outputs
  logic [LRP_NCOL-1:0]           row_bus;    // resolved row channels
  logic [LRP_NCCH-1:0]           col_bus;    // resolved column channels
  logic [LRP_NLE-1:0]            rsel_val;   // row selector outputs
  logic [LRP_NIO-1:0]            io_val;     // io input values
  logic [LRP_NIO-1:0]            io_drv;     // io drives channels
  logic [LRP_NPER-1:0]           per_raw;    // peripheral line sources
  lrp_per_s                      per;        // effective control lines
  logic [1:0]                    clk_edge;   // rising edge of clock lines

  wire       apb_acc  = i_psel & i_penable;   // access phase
  wire       wr       = apb_acc & i_pwrite;   // write strobe
  wire [3:0] ioe_idx  = i_paddr[5:2];         // io config index
  wire       hit_as   = (i_paddr == LRP_A_ASYNC);
  wire       hit_cd   = (i_paddr == LRP_A_COLDRV);
  wire       hit_rs   = (i_paddr == LRP_A_ROWSEL);
  wire       hit_ps   = (i_paddr == LRP_A_PSRC);
  wire       hit_pf   = (i_paddr == LRP_A_PFUNC);
  wire       hit_st   = (i_paddr == LRP_A_STAT);
  wire       hit_io   = (i_paddr[7:6] == LRP_A_IOPG) && ~|i_paddr[1:0]
                        && (ioe_idx < LRP_NIO);
  wire       mapped   = hit_as | hit_cd | hit_rs | hit_ps | hit_pf
                        | hit_st | hit_io;
  wire [31:0] stat_w  = {16'h0000, per, le_q}; // lines and element outputs

  // zero-wait slave, error on unmapped access
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc & ~mapped;
  assign o_prdata  = ~apb_acc  ? 32'h0000_0000
                   : hit_as    ? {30'h0, async_reg}
                   : hit_cd    ? {16'h0000, coldrv_reg}
                   : hit_rs    ? {16'h0000, rowsel_reg}
                   : hit_ps    ? {2'h0, psrc_reg}
                   : hit_pf    ? {30'h0, pfunc_reg}
                   : hit_st    ? stat_w
                   : hit_io    ? ioe_reg[ioe_idx]
                   : 32'h0000_0000;

  // register writes, taken in the access phase
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      async_reg  <= LRP_AS_NONE;
      coldrv_reg <= '0;
      rowsel_reg <= '0;
      psrc_reg   <= '0;
      pfunc_reg  <= '0;
      for (int n = 0; n < LRP_NIO; n++) begin
        ioe_reg[n] <= '0;
      end
    end else if (wr) begin
      if (hit_as) async_reg  <= i_pwdata[1:0];
      if (hit_cd) coldrv_reg <= i_pwdata[15:0];
      if (hit_rs) rowsel_reg <= i_pwdata[15:0];
      if (hit_ps) psrc_reg   <= i_pwdata[29:0];
      if (hit_pf) pfunc_reg  <= i_pwdata[1:0];
      if (hit_io) ioe_reg[ioe_idx] <= i_pwdata;
    end
  end

  // ***********************************************
  // logic element registers and row selectors
  // ***********************************************
  wire ctl_a = i_block_ctrl_line_a; // asserted high
  wire ctl_b = i_block_ctrl_line_b; // asserted high

  for (genvar k = 0; k < LRP_NLE; k++) begin : g_le
    logic st_reg;  // stored bit, inverted sense in load+preset
    logic st_next; // next stored bit
    logic pre_n;   // active-low preset
    logic clr_n;   // active-low clear
    logic din;     // clocked data into the register
    logic vis;     // register value with async forces applied
    wire  d   = i_elem_data_in_d[k];
    wire  ldp = (async_reg == LRP_AS_LDPRE);
    wire  ldo = (async_reg == LRP_AS_LDONLY);

    // clear wins over preset; unused controls sit high
    assign pre_n = ldp ? ~(ctl_a & ~ctl_b & ~d)
                 : ldo ? ~(ctl_a & d)
                 : 1'b1;
    assign clr_n = ldp ? ~(ctl_b | (ctl_a & d))
                 : ldo ? ~(ctl_a & ~d)
                 : 1'b1;
    assign din     = ldp ? ~i_le_d[k] : i_le_d[k];
    assign vis     = ~clr_n ? 1'b0 : ~pre_n ? 1'b1 : st_reg;
    assign st_next = ~clr_n ? 1'b0 : ~pre_n ? 1'b1 : din;
    assign le_q[k] = ldp ? ~vis : vis;

    // element register
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) st_reg <= 1'b0;
      else         st_reg <= st_next;
    end

    // 3:1 row selector over own output and own column pair
    wire [1:0] rs = rowsel_reg[2*k +: 2];
    assign rsel_val[k] = (rs == LRP_RS_LE)   ? le_q[k]
                       : (rs == LRP_RS_COLA) ? col_bus[2*k]
                       : col_bus[2*k+1];

    ld_pre_load_a: assert property (ldp && ctl_a && !ctl_b
      |-> o_le_out[k] == d) else $error("load+preset load wrong");
    ld_pre_clr_a: assert property (ldp && ctl_b
      |-> o_le_out[k]) else $error("load+preset clear not preset");
    ld_only_a: assert property ((ldo && !ctl_a) ##1 (ldo && !ctl_a)
      |-> o_le_out[k] == $past(i_le_d[k]))
      else $error("load-only register lost clocked data");
    col_drive_a: assert property (coldrv_reg[2*k+1]
      |-> o_col_chan[2*k+1] == o_le_out[k])
      else $error("column not driven by element");
    row_sel_a: assert property (rs == LRP_RS_COLA
      |-> o_row_chan[k] == o_col_chan[2*k])
      else $error("row selector picked wrong column");
  end

  // ***********************************************
  // channel resolution
  // ***********************************************
  // externals first, io inputs next, own block drivers last
  always_comb begin
    col_bus = i_col_ext;
    for (int j = LRP_NIOR; j < LRP_NIO; j++) begin
      if (io_drv[j]) begin
        col_bus[ioe_reg[j][19:16]] = io_val[j];
        col_bus[ioe_reg[j][24:21]] = io_val[j];
      end
    end
    for (int c = 0; c < LRP_NCCH; c++) begin
      if (coldrv_reg[c]) col_bus[c] = le_q[c/2];
    end
  end

  always_comb begin
    row_bus = i_row_ext;
    for (int j = 0; j < LRP_NIOR; j++) begin
      if (io_drv[j] && ioe_reg[j][20:16] < LRP_NCOL) begin
        row_bus[ioe_reg[j][19:16]] = io_val[j];
      end
      if (io_drv[j] && ioe_reg[j][25:21] < LRP_NCOL) begin
        row_bus[ioe_reg[j][24:21]] = io_val[j];
      end
    end
    for (int k = 0; k < LRP_NLE; k++) begin
      if (rowsel_reg[2*k +: 2] != LRP_RS_EXT) row_bus[k] = rsel_val[k];
    end
  end

  assign o_le_out      = le_q;
  assign o_row_chan    = row_bus;
  assign o_col_chan    = col_bus;
  assign o_block_local = {i_ded_in, row_bus};

  // ***********************************************
  // peripheral control network
  // ***********************************************
  for (genvar p = 0; p < LRP_NPER; p++) begin : g_per
    assign per_raw[p] = pick_src(psrc_reg[p*LRP_SRC_W +: LRP_SRC_W],
                                 i_ded_in, row_bus);
  end

  // shared lines serve one function at a time
  assign per.clk_a = per_raw[LRP_P_CLK_A];
  assign per.clr_a = per_raw[LRP_P_CLR_A];
  assign per.clk_b = ~pfunc_reg[LRP_F_LINE_B] & per_raw[LRP_P_CLK_B];
  assign per.oe_b  =  pfunc_reg[LRP_F_LINE_B] & per_raw[LRP_P_CLK_B];
  assign per.clr_b = ~pfunc_reg[LRP_F_LINE_A] & per_raw[LRP_P_CLR_B];
  assign per.oe_a  =  pfunc_reg[LRP_F_LINE_A] & per_raw[LRP_P_CLR_B];
  assign per.oe_c  = per_raw[LRP_P_OE_C];
  assign per.oe_d  = per_raw[LRP_P_OE_D];
  assign clk_edge  = {per.clk_b, per.clk_a} & ~clk_prev_reg;

  // last levels of the two clock lines
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) clk_prev_reg <= 2'h0;
    else         clk_prev_reg <= {per.clk_b, per.clk_a};
  end

  // ***********************************************
  // io elements
  // ***********************************************
  for (genvar j = 0; j < LRP_NIO; j++) begin : g_io
    lrp_ioe_cfg_s cfg;    // this element's configuration
    logic         q_reg;  // io register
    logic         routed; // signal from the channels
    logic         tick;   // selected clock line rose
    logic         clr;    // selected clear line asserted
    logic         oe_pk;  // selected enable line
    assign cfg = ioe_reg[j];

    if (j < LRP_NIOR) begin : g_row
      assign routed = pick_row(row_bus, cfg.out_sel) ^ cfg.invert;
    end else begin : g_col
      assign routed = col_bus[(j % 2) * LRP_CGRP + cfg.out_sel[2:0]]
                      ^ cfg.invert;
    end

    assign tick  = cfg.clk_sel ? clk_edge[1] : clk_edge[0];
    assign clr   = cfg.clr_sel ? per.clr_b : per.clr_a;
    assign oe_pk = (cfg.oe_sel == 3'h0) ? per.oe_a
                 : (cfg.oe_sel == 3'h1) ? per.oe_b
                 : (cfg.oe_sel == 3'h2) ? per.oe_c
                 : (cfg.oe_sel == 3'h3) ? per.oe_d : 1'b0;

    // register as input or output register, cleared by its line
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn)   q_reg <= 1'b0;
      else if (clr)  q_reg <= 1'b0;
      else if (tick) q_reg <= (cfg.reg_use == LRP_RG_IN)
                              ? i_pad_in[j] : routed;
    end

    assign io_val[j]    = (cfg.reg_use == LRP_RG_IN) ? q_reg : i_pad_in[j];
    assign io_drv[j]    = cfg.drv_en & cfg.dir[0];
    assign o_pad_out[j] = (cfg.reg_use == LRP_RG_OUT) ? q_reg : routed;
    assign o_pad_oe[j]  = (cfg.dir == LRP_IO_OUT) ? 1'b1
                        : (cfg.dir == LRP_IO_BIDIR) & oe_pk;

    io_in_reg_a: assert property ((cfg.reg_use == LRP_RG_IN) && tick
      && !clr && !wr |=> io_val[j] == $past(i_pad_in[j]))
      else $error("input register missed pad level");
  end

  // ***********************************************
  // bus and network checks
  // ***********************************************
  sequence s_cold_wr;
    wr && hit_cd;
  endsequence

  cold_wr_a: assert property (s_cold_wr
    |=> coldrv_reg == $past(i_pwdata[15:0]))
    else $error("column drive write lost");
  apb_err_a: assert property (apb_acc && !mapped
    |-> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  shared_excl_a: assert property (!(per.oe_b && per.clk_b)
    && !(per.oe_a && per.clr_b))
    else $error("shared line used twice");
endmodule // lrp_fabric
`default_nettype wire

// *** src/lrp_pkg.sv ***
// Purpose: shared sizes, offsets and types of the routing fabric
// Assumes: one logic block on one row of the 13-column variant
// Notes: offsets are APB byte addresses, one word per register
package lrp_pkg;
  // ***********************************************
  // fabric sizes
  // ***********************************************
  localparam int LRP_NCOL  = 13; // row channels, equal to the column count
  localparam int LRP_NCCH  = 16; // column channels per column
  localparam int LRP_NLE   = 8;  // logic elements per block
  localparam int LRP_NPER  = 6;  // peripheral control lines
  localparam int LRP_NDED  = 4;  // dedicated low-skew inputs
  localparam int LRP_NIOR  = 8;  // io elements at the row end
  localparam int LRP_NIO   = 10; // row io plus two column io elements
  localparam int LRP_CGRP  = 8;  // column channels one column io can pick
  localparam int LRP_SRC_W = 5;  // peripheral source code width

  // ***********************************************
  // register byte offsets
  // ***********************************************
  localparam logic [7:0] LRP_A_ASYNC  = 8'h00; // logic element async mode
  localparam logic [7:0] LRP_A_COLDRV = 8'h04; // column drive enables
  localparam logic [7:0] LRP_A_ROWSEL = 8'h08; // row selector codes
  localparam logic [7:0] LRP_A_PSRC   = 8'h0c; // peripheral line sources
  localparam logic [7:0] LRP_A_PFUNC  = 8'h10; // shared line functions
  localparam logic [7:0] LRP_A_STAT   = 8'h14; // read-only status
  localparam logic [1:0] LRP_A_IOPG   = 2'h1;  // io config page, 0x40 + 4*n

  // ***********************************************
  // field positions and codes
  // ***********************************************
  localparam int LRP_P_CLK_A = 0; // periph_clock_a
  localparam int LRP_P_CLK_B = 1; // periph_clock_b_or_oe_b
  localparam int LRP_P_CLR_A = 2; // periph_clear_a
  localparam int LRP_P_CLR_B = 3; // periph_clear_b_or_oe_a
  localparam int LRP_P_OE_C  = 4; // periph_out_en_c
  localparam int LRP_P_OE_D  = 5; // periph_out_en_d
  localparam int LRP_F_LINE_B = 0; // func bit of clock_b / oe_b line
  localparam int LRP_F_LINE_A = 1; // func bit of clear_b / oe_a line
  localparam logic [4:0] LRP_SRC_ROW = 5'h04; // first row channel source code

  typedef enum logic [1:0] {LRP_AS_NONE = 2'h0, LRP_AS_LDPRE = 2'h1,
                            LRP_AS_LDONLY = 2'h3} lrp_async_e;
  typedef enum logic [1:0] {LRP_RS_EXT = 2'h0, LRP_RS_LE = 2'h1,
                            LRP_RS_COLA = 2'h3, LRP_RS_COLB = 2'h2} lrp_rsel_e;
  typedef enum logic [1:0] {LRP_IO_OFF = 2'h0, LRP_IO_IN = 2'h1,
                            LRP_IO_BIDIR = 2'h3, LRP_IO_OUT = 2'h2} lrp_dir_e;
  typedef enum logic [1:0] {LRP_RG_NONE = 2'h0, LRP_RG_IN = 2'h1,
                            LRP_RG_OUT = 2'h3} lrp_ruse_e;

  // io element configuration word
  typedef struct packed {
    logic [5:0] rsvd;    // reads back as written, unused
    logic [4:0] tgt_b;   // second channel driven as input
    logic [4:0] tgt_a;   // first channel driven as input
    logic       drv_en;  // input drives channels
    logic       clr_sel; // 0 clear_a, 1 clear_b
    logic       clk_sel; // 0 clock_a, 1 clock_b
    logic [2:0] oe_sel;  // 0 oe_a, 1 oe_b, 2 oe_c, 3 oe_d
    logic [4:0] out_sel; // output channel select
    logic       invert;  // invert routed output
    logic [1:0] reg_use; // lrp_ruse_e
    logic [1:0] dir;     // lrp_dir_e
  } lrp_ioe_cfg_s;

  // effective peripheral control lines
  typedef struct packed {
    logic clk_a;
    logic clk_b;
    logic clr_a;
    logic clr_b;
    logic oe_a;
    logic oe_b;
    logic oe_c;
    logic oe_d;
  } lrp_per_s;
endpackage

// *** testbench/lrp_pad_model.sv ***
// Purpose: board logic standing at the device pads
// Assumes: one pad per io element, no pull resistors on the pads
// Notes: an undriven pad shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module lrp_pad_model
  import lrp_pkg::*;
(
  input  wire logic               i_sys_clk, // sample clock
  input  wire logic [LRP_NIO-1:0] i_pad_out, // device drive value
  input  wire logic [LRP_NIO-1:0] i_pad_oe,  // device drives pad
  input  wire logic [LRP_NIO-1:0] i_brd_val, // board drive value
  input  wire logic [LRP_NIO-1:0] i_brd_en,  // board drives pad
  output logic      [LRP_NIO-1:0] o_pad_lvl  // resolved pad level
);
  logic [LRP_NIO-1:0] last_lvl = '0; // previous resolved level
  // remember the level so a floating pad never repeats it
  always @(posedge i_sys_clk) begin
    last_lvl <= o_pad_lvl;
  end
  // device drive wins, then the board, else a toggling float
  assign o_pad_lvl = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_brd_en & i_brd_val)
                   | (~i_pad_oe & ~i_brd_en & ~last_lvl);
endmodule // lrp_pad_model
`default_nettype wire

// *** testbench/tb_lrp_fabric.sv ***
// Purpose: self-checking bench for the routing fabric
// Assumes: zero-wait apb slave, board model on the pads
// Notes: inputs change by nba on rising edges, level checks on falling edges, apb results right after each transfer
`timescale 1ns/1ns
`default_nettype none
module tb_lrp_fabric import lrp_pkg::*; ();
  logic        clk = 1'b0;                          // 20 mhz clock
  logic        rstn = 1'b0;                         // async reset, low
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0; // apb controls
  logic [7:0]  paddr = 8'h00;                       // apb address
  logic [31:0] pwdata = 32'h0, prdata, rdat;        // apb data
  logic        pready, pslverr, rerr;               // apb answer
  logic [7:0]  le_d = 8'h00, ldat = 8'h00, le_out;  // element data
  logic        cla = 1'b0, clb = 1'b0;              // load and clear lines
  logic [12:0] row_ext = 13'h0000, row, er;         // row channels
  logic [15:0] col_ext = 16'h1234, col;             // column channels
  logic [3:0]  ded = 4'h0;                          // dedicated inputs
  logic [16:0] loc;                                 // block local feed
  logic [9:0]  pin, pout, poe;                      // pads
  logic [9:0]  bval = 10'h000, ben = 10'h000;       // board drive
  int          fail_count = 0, n_compared = 0, k;   // counters
  // ***********************************************
  // clock, design and board
  // ***********************************************
  always #25 clk = ~clk;
  lrp_fabric dut (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_le_d(le_d), .i_elem_data_in_d(ldat),
    .i_block_ctrl_line_a(cla), .i_block_ctrl_line_b(clb), .o_le_out(le_out),
    .i_row_ext(row_ext), .i_col_ext(col_ext), .i_ded_in(ded), .o_row_chan(row),
    .o_col_chan(col), .o_block_local(loc), .i_pad_in(pin), .o_pad_out(pout),
    .o_pad_oe(poe));
  lrp_pad_model brd (.i_sys_clk(clk), .i_pad_out(pout), .i_pad_oe(poe),
    .i_brd_val(bval), .i_brd_en(ben), .o_pad_lvl(pin));
  // ***********************************************
  // tasks
  // ***********************************************
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
      $display("ERROR %0t: apb transfer never answered", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // verdict and end of run
  task close_out();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #(5000 * 50);
    fail_count++;
    close_out();
  end
  // ***********************************************
  // test sequence
  // ***********************************************
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, LRP_A_ASYNC, 32'h0);
    check(rdat, 32'h0);
    check(pready, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check(rerr, 32'h1);
    check(rdat, 32'h0);
    apb(1'b1, LRP_A_STAT, 32'hffff);
    check(rerr, 32'h0);
    // load only: line a forces the load data
    apb(1'b1, LRP_A_ASYNC, 32'h3);
    cla <= 1'b1;
    ldat <= 8'h5a;
    @(negedge clk) check(le_out, 8'h5a);
    @(posedge clk) cla <= 1'b0;
    le_d <= 8'hc3;
    repeat (2) @(posedge clk);
    @(negedge clk) check(le_out, 8'hc3);
    // load with preset: b sets all ones, a loads
    apb(1'b1, LRP_A_ASYNC, 32'h1);
    clb <= 1'b1;
    @(negedge clk) check(le_out, 8'hff);
    @(posedge clk) clb <= 1'b0;
    cla <= 1'b1;
    ldat <= 8'h3c;
    @(negedge clk) check(le_out, 8'h3c);
    @(posedge clk) cla <= 1'b0;
    le_d <= 8'ha6;
    repeat (2) @(posedge clk);
    @(negedge clk) check(le_out, 8'ha6);
    // column drive from element pairs
    apb(1'b1, LRP_A_COLDRV, 32'hffff);
    @(negedge clk);
    for (k = 0; k < 16; k++) check(col[k], le_d[k/2]);
    apb(1'b1, LRP_A_COLDRV, 32'h0);
    @(negedge clk) check(col, col_ext);
    // row selector codes own, col 2k+1, col 2k
    er = row_ext;
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, LRP_A_ROWSEL, 32'(16'h5555 * c));
      for (k = 0; k < 8; k++) er[k] = (c == 1) ? le_d[k] : col_ext[2*k + (c == 2)];
      @(negedge clk) check(row, er);
      check(loc, {ded, er});
    end
    // row io output over all 13 rows, odd ones inverted
    for (k = 0; k < 13; k++) begin
      apb(1'b1, 8'h40, 32'(2 + ((k % 2) << 4) + (k << 5)));
      @(negedge clk) check(pout[0], er[k] ^ k[0]);
      check(poe[0], 32'h1);
    end
    // column io outputs over their halves
    for (k = 0; k < 8; k++) begin
      apb(1'b1, 8'h60, 32'(2 + (k << 5)));
      apb(1'b1, 8'h64, 32'(2 + (k << 5)));
      @(negedge clk) check(pout[8], col_ext[k]);
      check(pout[9], col_ext[k+8]);
    end
    // io inputs driving two channels each
    apb(1'b1, 8'h44, 32'(1 + (1 << 15) + (9 << 16) + (11 << 21)));
    apb(1'b1, 8'h64, 32'(1 + (1 << 15) + (3 << 16) + (14 << 21)));
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk) ben <= 10'h202;
      bval <= v ? 10'h202 : 10'h000;
      @(negedge clk) check({row[9], row[11]}, 32'(v * 3));
      check({col[3], col[14]}, 32'(v * 3));
    end
    // peripheral sources: dedicated and row channels
    apb(1'b1, LRP_A_PSRC, 32'(3 + (4 << 5) + (2 << 10) + (1 << 15) + (5 << 25)));
    apb(1'b1, LRP_A_ROWSEL, 32'h5);
    apb(1'b1, 8'h48, 32'h3);
    check(rerr, 32'h0);
    ded <= 4'h2;
    le_d <= 8'ha7;
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, LRP_A_PFUNC, 32'(f));
      @(negedge clk) check(poe[2], f[1]);
      apb(1'b0, LRP_A_STAT, 32'h0);
      check({rdat[11], rdat[10]}, 32'(f));
      check({rdat[9], rdat[8], rdat[7:0]}, 32'h1a7);
    end
    apb(1'b0, 8'h48, 32'h0);
    check(rdat, 32'h3);
    // io output register on clock a, cleared by clear a
    apb(1'b1, 8'h4c, 32'(2 + (3 << 2) + (1 << 5)));
    @(negedge clk) check(pout[3], 32'h0);
    @(posedge clk) ded <= 4'ha;
    repeat (3) @(posedge clk);
    @(negedge clk) check(pout[3], 32'h1);
    @(posedge clk) ded <= 4'h6;
    repeat (3) @(posedge clk);
    @(negedge clk) check(pout[3], 32'h0);
    close_out();
  end
endmodule // tb_lrp_fabric
`default_nettype wire
